/* src/psx_pkg.sv */
// package for the pixel program arithmetic and texture load block
// Operation
// - multiply writes per-component product of first and second source
// - no-operation changes no register and no output
// - subtract writes first source minus second source per component, floored at zero
// - texture load fills texture register with sampled rgba colour
// - texture load uses stage equal to destination register number
// - sampling obeys the stage attribute settings set beforehand
// - sampler looks up colour at u, v, w, q with stage attributes
// - stage coordinates are interpolated per-vertex coordinate sets
// - coordinate sets map one-to-one to stages by default, set 0 first
// - fixed-function index may reassign sets; programmable uses outputs
// - texture load accepted only in program versions 1.0 to 1.3
package psx_pkg;
   localparam int COMP_W    = 8;
   localparam int NUM_REGS  = 4;
   localparam int REG_IDX_W = 2;
   localparam int COORD_W   = 16;
   localparam int VER_W     = 4;
   // version code: minor number of 1.x
   localparam logic [3:0] VER_MIN_TEX = 4'h0;
   localparam logic [3:0] VER_MAX_TEX = 4'h3;
   localparam logic [7:0] COMP_ZERO   = 8'h00;
   localparam int FRAC_SHIFT = 8;

   typedef enum logic [1:0] {PSX_NOP, PSX_MUL, PSX_SUB, PSX_TEX} psx_op_t;
   typedef enum logic [1:0] {PSX_VCOL, PSX_CONST, PSX_TEXR, PSX_TEMP}
      psx_bank_t;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      logic [7:0] a;
   } psx_rgba_t;

   typedef struct packed {
      logic [15:0] u;
      logic [15:0] v;
      logic [15:0] w;
      logic [15:0] q;
   } psx_coord_t;

   typedef struct packed {
      psx_op_t     op;
      psx_bank_t   dst_bank;
      logic [1:0]  dst_idx;
      psx_bank_t   s0_bank;
      logic [1:0]  s0_idx;
      psx_bank_t   s1_bank;
      logic [1:0]  s1_idx;
   } psx_instr_t;
endpackage

/* src/psx_comp_alu.sv */
// one colour component multiply or subtract lane
`timescale 1ns/100ps
module psx_comp_alu (
   input  wire psx_pkg::psx_op_t op,
   input  wire logic [7:0]       a,
   input  wire logic [7:0]       b,
   output logic [7:0]            y
);
   logic [15:0] prod;
   always_comb begin
      // unsigned 0..1 fixed point, product shifted right by 8, so full scale counts as 255/256
      prod = a * b;
      case (op)
         psx_pkg::PSX_MUL: y = 8'(prod >> psx_pkg::FRAC_SHIFT);
         psx_pkg::PSX_SUB:
            y = (a > b) ? a - b : psx_pkg::COMP_ZERO;
         default:          y = a;
      endcase
   end
endmodule

/* src/psx_exec.sv */
// pixel program execution: mul, sub, nop and texture load
`timescale 1ns/100ps
module psx_exec #(
   parameter int NREG = 4
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 instr_valid,
   output logic                      instr_ready,
   input  wire psx_pkg::psx_instr_t  instr,
   input  wire logic [3:0]           prog_minor_ver,
   input  wire psx_pkg::psx_rgba_t [NREG-1:0] colour_input_reg,
   input  wire psx_pkg::psx_rgba_t [NREG-1:0] constant_reg,
   input  wire logic                 fixed_function_vp,
   input  wire logic [NREG-1:0][1:0] coord_set_select,
   input  wire psx_pkg::psx_coord_t [NREG-1:0] interp_coord_set,
   input  wire psx_pkg::psx_coord_t [NREG-1:0] vertex_coord_output,
   output psx_pkg::psx_coord_t       smp_coord,
   output logic [1:0]                smp_stage,
   output logic                      smp_req,
   input  wire logic                 smp_ack,
   input  wire psx_pkg::psx_rgba_t   smp_colour,
   output psx_pkg::psx_rgba_t [NREG-1:0] texture_reg,
   output psx_pkg::psx_rgba_t [NREG-1:0] temporary_reg,
   output logic                      done,
   output logic                      tex_rejected
);
   typedef enum {ST_IDLE, ST_SAMPLE} psx_st_t;
   psx_st_t                   st, next_st;
   psx_pkg::psx_rgba_t [NREG-1:0] next_texture_reg, next_temporary_reg;
   logic                      next_done, next_tex_rejected;
   logic [1:0]                tex_stage, next_tex_stage;
   psx_pkg::psx_rgba_t        s0, s1, res;

   // operand fetch from the four register banks
   function automatic psx_pkg::psx_rgba_t pick(psx_pkg::psx_bank_t bk,
                                               logic [1:0] ix);
      case (bk)
         psx_pkg::PSX_VCOL:  pick = colour_input_reg[ix];
         psx_pkg::PSX_CONST: pick = constant_reg[ix];
         psx_pkg::PSX_TEXR:  pick = texture_reg[ix];
         default:            pick = temporary_reg[ix];
      endcase
   endfunction

   assign s0 = pick(instr.s0_bank, instr.s0_idx);
   assign s1 = pick(instr.s1_bank, instr.s1_idx);

   // four lanes side by side
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_lane
         psx_comp_alu u_lane (
            .op (instr.op),
            .a  (s0[c*psx_pkg::COMP_W +: psx_pkg::COMP_W]),
            .b  (s1[c*psx_pkg::COMP_W +: psx_pkg::COMP_W]),
            .y  (res[c*psx_pkg::COMP_W +: psx_pkg::COMP_W])
         );
      end
   endgenerate

   // late program versions refuse texture loads outright
   wire tex_ok = (prog_minor_ver >= psx_pkg::VER_MIN_TEX) &&
                 (prog_minor_ver <= psx_pkg::VER_MAX_TEX);

   // no new work while a sample is outstanding
   assign instr_ready = (st == ST_IDLE);

   // coordinate source for the stage in flight
   always_comb begin
      if (fixed_function_vp)
         smp_coord = interp_coord_set[coord_set_select[tex_stage]];
      else
         smp_coord = vertex_coord_output[tex_stage];
   end
   // with coord_set_select[n] == n the default one-to-one map holds
   // coordinates reach the sampler already interpolated
   assign smp_stage = tex_stage;
   assign smp_req   = (st == ST_SAMPLE);

   always_comb begin
      next_st            = st;
      next_texture_reg   = texture_reg;
      next_temporary_reg = temporary_reg;
      next_tex_stage     = tex_stage;
      next_done          = 1'b0;
      next_tex_rejected  = 1'b0;
      case (st)
         ST_IDLE: begin
            if (instr_valid) begin
               case (instr.op)
                  // arithmetic completes in one cycle
                  psx_pkg::PSX_MUL, psx_pkg::PSX_SUB: begin
                     if (instr.dst_bank == psx_pkg::PSX_TEXR)
                        next_texture_reg[instr.dst_idx] = res;
                     else
                        next_temporary_reg[instr.dst_idx] = res;
                     next_done = 1'b1;
                  end
                  psx_pkg::PSX_TEX: begin
                     if (tex_ok) begin
                        next_tex_stage = instr.dst_idx;
                        next_st        = ST_SAMPLE;
                     end else begin
                        next_tex_rejected = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
         ST_SAMPLE: begin
            // sampler applies its own stage attributes
            // instr_ready stays low, so the stream waits here
            if (smp_ack) begin
               next_texture_reg[tex_stage] = smp_colour;
               next_done = 1'b1;
               next_st   = ST_IDLE;
            end
         end
         default: next_st = ST_IDLE;
      endcase
   end

   // register stage; reset clears both register banks
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st            <= ST_IDLE;
         texture_reg   <= '0;
         temporary_reg <= '0;
         tex_stage     <= 2'h0;
         done          <= 1'b0;
         tex_rejected  <= 1'b0;
      end else begin
         st            <= next_st;
         texture_reg   <= next_texture_reg;
         temporary_reg <= next_temporary_reg;
         tex_stage     <= next_tex_stage;
         done          <= next_done;
         tex_rejected  <= next_tex_rejected;
      end
   end

   // every check stays idle while reset is held
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   mul_result_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_MUL &&
      instr.dst_bank == psx_pkg::PSX_TEMP
      |=> temporary_reg[$past(instr.dst_idx)] == $past(res) && done)
      else $error("multiply result not written");
   nop_still_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_NOP
      |=> $stable(temporary_reg) && $stable(texture_reg) && !done)
      else $error("nop changed state");
   sub_result_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_SUB &&
      instr.dst_bank == psx_pkg::PSX_TEMP
      |=> temporary_reg[$past(instr.dst_idx)] == $past(res))
      else $error("subtract result not written");
   tex_fill_a: assert property (
      smp_req && smp_ack
      |=> texture_reg[$past(smp_stage)] == $past(smp_colour) && done)
      else $error("texture colour not loaded");
   tex_stage_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_TEX && tex_ok
      |=> smp_req && smp_stage == $past(instr.dst_idx))
      else $error("wrong sample stage");
   tex_reject_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_TEX && !tex_ok
      |=> tex_rejected && !smp_req && $stable(texture_reg))
      else $error("late version texture load not rejected");
   req_hold_a: assert property (
      smp_req && !smp_ack |=> smp_req && $stable(smp_stage))
      else $error("sample request dropped");
   coord_map_a: assert property (
      smp_req && !fixed_function_vp
      |-> smp_coord == vertex_coord_output[smp_stage])
      else $error("programmable coordinate source wrong");
   busy_hold_a: assert property (
      smp_req |-> !instr_ready)
      else $error("accepted while sampling");

   // arithmetic into a texture register, completion and refusal
   tex_dst_mul_a: assert property (
      instr_valid && instr_ready && instr.op == psx_pkg::PSX_MUL &&
      instr.dst_bank == psx_pkg::PSX_TEXR
      |=> texture_reg[$past(instr.dst_idx)] == $past(res) && done)
      else $error("multiply into texture register not written");
   done_cause_a: assert property (
      done |-> $past(smp_req && smp_ack) ||
               $past(instr_valid && instr_ready &&
                     (instr.op == psx_pkg::PSX_MUL ||
                      instr.op == psx_pkg::PSX_SUB)))
      else $error("done without a completed instruction");
   rej_cause_a: assert property (
      tex_rejected |-> $past(instr_valid && instr_ready && !tex_ok &&
                             instr.op == psx_pkg::PSX_TEX))
      else $error("texture load refused without cause");
   reject_quiet_a: assert property (
      tex_rejected |-> !done && !smp_req)
      else $error("refused texture load still ran");
   req_end_a: assert property (
      smp_req && smp_ack |=> !smp_req && instr_ready)
      else $error("sample request outlived its answer");
   busy_write_a: assert property (
      smp_req && !smp_ack |=> $stable(temporary_reg) && !done)
      else $error("register written while sampling");
   coord_ff_a: assert property (
      smp_req && fixed_function_vp
      |-> smp_coord == interp_coord_set[coord_set_select[smp_stage]])
      else $error("fixed-function coordinate source wrong");
   coord_ident_a: assert property (
      smp_req && fixed_function_vp &&
      coord_set_select[smp_stage] == smp_stage
      |-> smp_coord == interp_coord_set[smp_stage])
      else $error("default coordinate map broken");

   tex_cov_c: cover property (smp_req ##1 smp_ack);
   mul_cov_c: cover property (instr_valid && instr.op == psx_pkg::PSX_MUL);
   rej_cov_c: cover property (tex_rejected);
   sub_cov_c: cover property (instr_valid && instr.op == psx_pkg::PSX_SUB);
   busy_cov_c: cover property (smp_req && instr_valid);
endmodule

/* bench/psx_smp_model.sv */
// sampling-stage model: answers requests after a set latency
`timescale 1ns/100ps
module psx_smp_model (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic [1:0]          lat,
   input  wire logic                smp_req,
   input  wire logic [1:0]          smp_stage,
   input  wire psx_pkg::psx_coord_t smp_coord,
   output logic                     smp_ack,
   output psx_pkg::psx_rgba_t       smp_colour
);
   logic [1:0] cnt;
   initial smp_colour = 32'h3c3c3c3c;
   always @(posedge ref_clk) begin
      smp_colour <= ~smp_colour;
      smp_ack    <= 1'b0;
      cnt        <= cnt + 2'h1;
      if (!rst_n || smp_ack || !smp_req)
         cnt <= 2'h0;
      else if (cnt >= lat) begin
         // stage attribute folded into the colour
         smp_ack    <= 1'b1;
         smp_colour <= {smp_coord.u[7:0], smp_coord.v[7:0],
                        smp_coord.w[7:0], smp_coord.q[7:0]}
                       ^ {4{smp_stage, 6'h15}};
      end
   end
endmodule

/* bench/psx_exec_tb_top.sv */
// bench top: random instruction stream checked against a reference model
`timescale 1ns/100ps
module psx_exec_tb_top;
   logic                      ref_clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      instr_valid = 1'b0;
   psx_pkg::psx_instr_t       instr = '0;
   logic [3:0]                prog_minor_ver = 4'h0;
   psx_pkg::psx_rgba_t [3:0]  colour_input_reg = '0;
   psx_pkg::psx_rgba_t [3:0]  constant_reg = '0;
   logic                      fixed_function_vp = 1'b0;
   logic [3:0][1:0]           coord_set_select = 8'he4;
   psx_pkg::psx_coord_t [3:0] interp_coord_set = '0;
   psx_pkg::psx_coord_t [3:0] vertex_coord_output = '0;
   logic [1:0]                lat = 2'h0;
   logic                      instr_ready, smp_req, smp_ack, done;
   logic                      tex_rejected;
   logic [1:0]                smp_stage;
   psx_pkg::psx_coord_t       smp_coord;
   psx_pkg::psx_rgba_t        smp_colour;
   psx_pkg::psx_rgba_t [3:0]  texture_reg, temporary_reg;
   psx_pkg::psx_rgba_t [3:0]  tr = '0;
   psx_pkg::psx_rgba_t [3:0]  tp = '0;
   int                        seed = 32'h651504cd;
   int                        bad_count = 0;
   int                        n_compared = 0;

   always #4 ref_clk = ~ref_clk;

   psx_exec dut (.ref_clk, .rst_n, .instr_valid, .instr_ready, .instr,
      .prog_minor_ver, .colour_input_reg, .constant_reg, .fixed_function_vp,
      .coord_set_select, .interp_coord_set, .vertex_coord_output, .smp_coord,
      .smp_stage, .smp_req, .smp_ack, .smp_colour, .texture_reg,
      .temporary_reg, .done, .tex_rejected);

   psx_smp_model far_end (.ref_clk, .rst_n, .lat, .smp_req, .smp_stage,
      .smp_coord, .smp_ack, .smp_colour);

   task automatic check(input logic [127:0] seen, input logic [127:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic psx_pkg::psx_rgba_t src(psx_pkg::psx_bank_t b,
                                              logic [1:0] i);
      case (b)
         psx_pkg::PSX_VCOL:  return colour_input_reg[i];
         psx_pkg::PSX_CONST: return constant_reg[i];
         psx_pkg::PSX_TEXR:  return tr[i];
         default:            return tp[i];
      endcase
   endfunction

   task automatic run_one();
      logic [31:0]         a, b, e;
      logic [15:0]         p;
      logic [1:0]          d;
      logic [28:0]         r;
      psx_pkg::psx_coord_t c;
      int                  k;
      r = 29'($random(seed));
      // versions 1.0 to 1.5; texture loads aim at a texture register
      if (r[14:11] > 4'h5)
         r[14:11] = 4'h1;
      if (psx_pkg::psx_op_t'(r[28:27]) == psx_pkg::PSX_TEX)
         r[26:25] = psx_pkg::PSX_TEXR;
      {instr, prog_minor_ver, fixed_function_vp, coord_set_select, lat} = r;
      for (k = 0; k < 4; k++) begin
         colour_input_reg[k] = $random(seed);
         constant_reg[k] = $random(seed);
         interp_coord_set[k] = {$random(seed), $random(seed)};
         vertex_coord_output[k] = {$random(seed), $random(seed)};
      end
      d = instr.dst_idx;
      a = src(instr.s0_bank, instr.s0_idx);
      b = src(instr.s1_bank, instr.s1_idx);
      for (k = 0; k < 32; k += 8) begin
         p = a[k+:8] * b[k+:8];
         if (instr.op == psx_pkg::PSX_MUL)
            e[k+:8] = p[15:8];
         else
            e[k+:8] = (a[k+:8] > b[k+:8]) ? a[k+:8] - b[k+:8] : 8'h00;
      end
      c = fixed_function_vp ? interp_coord_set[coord_set_select[d]]
                            : vertex_coord_output[d];
      // valid stays up: back to back, and refused while sampling
      instr_valid = 1'b1;
      check(instr_ready, 1'b1, "ready");
      @(negedge ref_clk);
      if (instr.op == psx_pkg::PSX_TEX && prog_minor_ver < 4'h4) begin
         for (k = 0; k < 12 && done !== 1'b1; k++) begin
            check({smp_req, instr_ready}, 2'h2, "busy");
            check(smp_stage, d, "stage");
            check(smp_coord, c, "coord");
            @(negedge ref_clk);
         end
         tr[d] = {c.u[7:0], c.v[7:0], c.w[7:0], c.q[7:0]} ^ {4{d, 6'h15}};
         check({done, tex_rejected}, 2'h2, "tex end");
      end else if (instr.op == psx_pkg::PSX_TEX)
         check({done, tex_rejected}, 2'h1, "reject");
      else if (instr.op == psx_pkg::PSX_NOP)
         check({done, tex_rejected, smp_req}, 3'h0, "nop");
      else begin
         if (instr.dst_bank == psx_pkg::PSX_TEXR)
            tr[d] = e;
         else
            tp[d] = e;
         check({done, tex_rejected}, 2'h2, "arith end");
      end
      check(texture_reg, tr, "texture_reg");
      check(temporary_reg, tp, "temporary_reg");
   endtask

   initial begin
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (300) run_one();
      instr_valid = 1'b0;
      summarize();
   end

   initial begin
      #60000;
      bad_count++;
      summarize();
   end
endmodule
